/* File: logic/ps_regs.vh */
`ifndef PS_REGS_VH
`define PS_REGS_VH

// ****************************************
// Register indices (byte address is four times the index)
// ****************************************
`define PS_IDX_PC_LOW 6'h06
`define PS_IDX_TBL_PTR 6'h07
`define PS_IDX_TBL_HIGH 6'h08
`define PS_IDX_STATUS 6'h0c
`define PS_IDX_MSB 7
`define PS_IDX_LSB 2

// ****************************************
// Program counter and vectors
// ****************************************
`define PS_PC_W 11
`define PS_PC_ONE 11'h001
`define PS_VEC_RESET 11'h000
`define PS_VEC_EXT 11'h004
`define PS_VEC_TIMER 11'h008
`define PS_LAST_PAGE 3'h7
`define PS_PAGE 10:8
`define PS_PM_LAST 11'h7ff

// ****************************************
// Program word fields
// ****************************************
`define PS_WORD_W 14
`define PS_WORD_LO 7:0
`define PS_WORD_HI 13:8
`define PS_HIGH_PAD 2'h0

// ****************************************
// Instruction phases, one-hot
// ****************************************
`define PS_PH0 4'h1
`define PS_PH1 4'h2
`define PS_PH2 4'h4
`define PS_PH3 4'h8

// ****************************************
// Return stack
// ****************************************
`define PS_STK_EMPTY 2'h0
`define PS_STK_ONE 2'h1
`define PS_STK_DEPTH 2'h2

// ****************************************
// Start-up timer, in system clock periods (1024)
// ****************************************
`define PS_SST_TSYS 11'h400
`define PS_SST_CYCLES (`PS_SST_TSYS * 11'h001)
`define PS_CNT_ZERO 11'h000

`endif

/* File: logic/ps_phase_gen.v */
`timescale 1ns/1ns
`include "ps_regs.vh"

module ps_phase_gen (
  input wire sys_clk_i,
  input wire reset_i,
  input wire hold_i,
  input wire restart_i,
  output reg [3:0] phase_o,
  output wire run_o
);

  reg [10:0] startup_cnt;

  assign run_o = (startup_cnt == `PS_CNT_ZERO) & ~hold_i;

  // ****************************************
  // Start-up wait and phase ring
  // ****************************************
  always @(posedge sys_clk_i) begin
    if (reset_i || restart_i) begin
      startup_cnt <= `PS_SST_CYCLES;
      phase_o <= `PS_PH0;
    end else if (startup_cnt != `PS_CNT_ZERO) begin
      startup_cnt <= startup_cnt - 11'h001;
    end else if (!hold_i) begin
      phase_o <= {phase_o[2:0], phase_o[3]};
    end
  end

endmodule // ps_phase_gen

/* File: logic/ps_prog_mem.v */
`timescale 1ns/1ns
`include "ps_regs.vh"

module ps_prog_mem (
  input wire sys_clk_i,
  input wire reset_i,
  input wire wr_en_i,
  input wire [10:0] wr_addr_i,
  input wire [13:0] wr_data_i,
  input wire rd_en_i,
  input wire [10:0] rd_addr_i,
  output reg [13:0] rd_data_o
);

  reg [13:0] mem [0:`PS_PM_LAST];

  // ****************************************
  // Registered read, plain write port
  // ****************************************
  always @(posedge sys_clk_i) begin
    if (wr_en_i) begin
      mem[wr_addr_i] <= wr_data_i;
    end
  end

  always @(posedge sys_clk_i) begin
    if (reset_i) begin
      rd_data_o <= 14'h0000;
    end else if (rd_en_i) begin
      rd_data_o <= mem[rd_addr_i];
    end
  end

endmodule // ps_prog_mem

/* File: logic/ps_sequencer.v */
// Functional notes
// - Four clocks make one instruction cycle
// - Fetch overlaps execute; transfers add dummy
// - Eleven bit counter, 2048 words
// - Counter increments after each fetch
// - Taken skip discards fetch, lands PC+2
// - Low byte write jumps within page
// - Reset starts execution at zero
// - External request vectors to 004H
// - Timer overflow vectors to 008H
// - Fourteen bit words, PC or table addressed
// - Table address from page or 111
// - Table word splits low byte, high register
// - Pointer read-write, high byte read-only
// - Table reads take two cycles
// - Two hidden stack entries, no access
// - Call pushes, return pops counter
// - Reset leaves stack empty
// - Full stack holds interrupts until pop
// - Call on full stack drops oldest
// - Start-up wait 1024 clocks
// - Vector clears flag and global enable
// - Only counter saved, never status
`timescale 1ns/1ns
`include "ps_regs.vh"

module ps_sequencer (
  input wire sys_clk_i,
  input wire reset_i,
  input wire [7:0] avs_address_i,
  input wire avs_read_i,
  input wire avs_write_i,
  input wire [31:0] avs_writedata_i,
  input wire [3:0] avs_byteenable_i,
  output reg [31:0] avs_readdata_o,
  output wire avs_waitrequest_o,
  input wire pm_wr_en_i,
  input wire [10:0] pm_wr_addr_i,
  input wire [13:0] pm_wr_data_i,
  input wire ctl_jump_i,
  input wire ctl_call_i,
  input wire ctl_return_i,
  input wire ctl_return_int_i,
  input wire ctl_skip_i,
  input wire ctl_tab_cur_i,
  input wire ctl_tab_last_i,
  input wire ctl_halt_i,
  input wire [10:0] ctl_target_i,
  input wire [7:0] ctl_dest_addr_i,
  input wire wake_i,
  input wire global_interrupt_enable_i,
  input wire external_interrupt_flag_i,
  input wire ext_int_en_i,
  input wire timer_interrupt_flag_i,
  input wire timer_int_en_i,
  output reg [13:0] instr_o,
  output reg instr_valid_o,
  output reg [10:0] exec_addr_o,
  output wire [3:0] phase_o,
  output wire cycle_end_o,
  output reg tab_low_we_o,
  output reg [7:0] tab_low_addr_o,
  output reg [7:0] tab_low_data_o,
  output reg ext_int_ack_o,
  output reg timer_int_ack_o,
  output reg gie_clear_o,
  output reg gie_set_o
);

  localparam ST_RUN = 2'b01;
  localparam ST_HALT = 2'b10;

  reg [1:0] state;
  reg [10:0] pc;
  reg [10:0] fetch_addr;
  reg [10:0] tab_addr;
  reg [7:0] tab_dest;
  reg tab_pending;
  reg [10:0] stk0;
  reg [10:0] stk1;
  reg [1:0] stack_level;
  reg [7:0] table_pointer;
  reg [7:0] table_high_byte;
  reg av_ack;
  reg [7:0] next_rd_byte;
  wire run;
  wire [13:0] mem_q;
  wire fetch_now;
  wire cycle_end;
  wire [5:0] idx;
  wire av_req;
  wire hit_pc_low;
  wire pc_low_wr;
  wire stack_full;
  wire do_jump;
  wire do_call;
  wire do_return;
  wire do_return_int;
  wire do_skip;
  wire do_tab;
  wire do_halt;
  wire int_ok;
  wire ext_want;
  wire ext_take;
  wire timer_take;
  wire [10:0] mem_rd_addr;
  wire ctl_busy;
  wire timer_want;
  wire pcl_ready;

  // ****************************************
  // Phase generation and program memory
  // ****************************************
  ps_phase_gen u_phase (
    .sys_clk_i(sys_clk_i),
    .reset_i(reset_i),
    .hold_i(state == ST_HALT),
    .restart_i((state == ST_HALT) & wake_i),
    .phase_o(phase_o),
    .run_o(run)
  );

  assign mem_rd_addr = tab_pending ? tab_addr : pc;

  ps_prog_mem u_mem (
    .sys_clk_i(sys_clk_i),
    .reset_i(reset_i),
    .wr_en_i(pm_wr_en_i),
    .wr_addr_i(pm_wr_addr_i),
    .wr_data_i(pm_wr_data_i),
    .rd_en_i(fetch_now),
    .rd_addr_i(mem_rd_addr),
    .rd_data_o(mem_q)
  );

  assign fetch_now = run & phase_o[0];
  assign cycle_end = run & phase_o[3];
  assign cycle_end_o = cycle_end;

  // ****************************************
  // Decoder controls, only while a real instruction executes
  // ****************************************
  assign do_jump = instr_valid_o & ctl_jump_i;
  assign do_call = instr_valid_o & ctl_call_i;
  assign do_return = instr_valid_o & (ctl_return_i | ctl_return_int_i);
  assign do_return_int = instr_valid_o & ctl_return_int_i;
  assign do_skip = instr_valid_o & ctl_skip_i;
  assign do_tab = instr_valid_o & (ctl_tab_cur_i | ctl_tab_last_i);
  assign do_halt = instr_valid_o & ctl_halt_i;
  assign stack_full = (stack_level == `PS_STK_DEPTH);


  // ****************************************
  // Interrupt gating
  // ****************************************
  // A control op owns the sequencer this cycle, so an interrupt waits one cycle, two after a table read, and past a halt until wake
  assign ctl_busy = do_jump | do_call | do_return | do_skip | do_tab | do_halt;
  assign int_ok = ~ctl_busy & ~stack_full;
  assign ext_want = global_interrupt_enable_i & external_interrupt_flag_i & ext_int_en_i;
  assign timer_want = global_interrupt_enable_i & timer_interrupt_flag_i & timer_int_en_i;
  assign ext_take = int_ok & ext_want;
  assign timer_take = int_ok & ~ext_want & timer_want;

  // ****************************************
  // Avalon slave
  // ****************************************
  assign idx = avs_address_i[`PS_IDX_MSB:`PS_IDX_LSB];
  assign av_req = avs_read_i | avs_write_i;
  assign hit_pc_low = (idx == `PS_IDX_PC_LOW);
  assign avs_waitrequest_o = av_req & ~av_ack;
  assign pc_low_wr = avs_write_i & av_ack & hit_pc_low & avs_byteenable_i[0];
  // A low byte write waits for the cycle end so the jump lands on a boundary
  assign pcl_ready = ~(avs_write_i & hit_pc_low) | phase_o[2] | ~run;

  always @* begin
    next_rd_byte = 8'h00;
    case (idx)
      `PS_IDX_PC_LOW: next_rd_byte = exec_addr_o[7:0];
      `PS_IDX_TBL_PTR: next_rd_byte = table_pointer;
      `PS_IDX_TBL_HIGH: next_rd_byte = table_high_byte;
      default: next_rd_byte = 8'h00;
    endcase
  end

  always @(posedge sys_clk_i) begin
    if (reset_i) begin
      av_ack <= 1'b0;
      avs_readdata_o <= 32'h0000_0000;
      table_pointer <= 8'h00;
    end else begin
      av_ack <= av_req & ~av_ack & pcl_ready;
      if (avs_read_i && !av_ack) begin
        if (idx == `PS_IDX_STATUS) begin
          avs_readdata_o <= {16'h0000, stack_level, state == ST_HALT, instr_valid_o, tab_pending, pc};
        end else begin
          avs_readdata_o <= {24'h00_0000, next_rd_byte};
        end
      end
      if (avs_write_i && av_ack && idx == `PS_IDX_TBL_PTR && avs_byteenable_i[0]) begin
        table_pointer <= avs_writedata_i[7:0];
      end
    end
  end

  // ****************************************
  // Sequencing, stack and table reads
  // ****************************************
  always @(posedge sys_clk_i) begin
    if (reset_i) begin
      pc <= `PS_VEC_RESET;
      fetch_addr <= `PS_VEC_RESET;
      exec_addr_o <= `PS_VEC_RESET;
      instr_o <= 14'h0000;
      instr_valid_o <= 1'b0;
      tab_pending <= 1'b0;
      tab_addr <= 11'h000;
      tab_dest <= 8'h00;
      stk0 <= 11'h000;
      stk1 <= 11'h000;
      stack_level <= `PS_STK_EMPTY;
      table_high_byte <= 8'h00;
      tab_low_we_o <= 1'b0;
      tab_low_addr_o <= 8'h00;
      tab_low_data_o <= 8'h00;
      ext_int_ack_o <= 1'b0;
      timer_int_ack_o <= 1'b0;
      gie_clear_o <= 1'b0;
      gie_set_o <= 1'b0;
      state <= ST_RUN;
    end else begin
      tab_low_we_o <= 1'b0;
      ext_int_ack_o <= 1'b0;
      timer_int_ack_o <= 1'b0;
      gie_clear_o <= 1'b0;
      gie_set_o <= 1'b0;
      if (fetch_now && !tab_pending) begin
        fetch_addr <= pc;
        pc <= pc + `PS_PC_ONE;
      end
      if (pc_low_wr) begin
        pc <= {pc[`PS_PAGE], avs_writedata_i[7:0]};
        instr_valid_o <= 1'b0;
      end else if (cycle_end) begin
        if (tab_pending) begin
          tab_pending <= 1'b0;
          table_high_byte <= {`PS_HIGH_PAD, mem_q[`PS_WORD_HI]};
          tab_low_we_o <= 1'b1;
          tab_low_addr_o <= tab_dest;
          tab_low_data_o <= mem_q[`PS_WORD_LO];
          instr_valid_o <= 1'b1;
        end else if (do_return) begin
          pc <= stk0;
          stk0 <= stk1;
          if (stack_level != `PS_STK_EMPTY) begin
            stack_level <= stack_level - `PS_STK_ONE;
          end
          gie_set_o <= do_return_int;
          instr_valid_o <= 1'b0;
        end else if (do_call) begin
          stk1 <= stk0;
          stk0 <= fetch_addr;
          if (!stack_full) begin
            stack_level <= stack_level + `PS_STK_ONE;
          end
          pc <= ctl_target_i;
          instr_valid_o <= 1'b0;
        end else if (do_jump) begin
          pc <= ctl_target_i;
          instr_valid_o <= 1'b0;
        end else if (do_skip) begin
          instr_valid_o <= 1'b0;
        end else if (do_tab) begin
          tab_addr <= {ctl_tab_last_i ? `PS_LAST_PAGE : exec_addr_o[`PS_PAGE], table_pointer};
          tab_dest <= ctl_dest_addr_i;
          tab_pending <= 1'b1;
          instr_o <= mem_q;
          exec_addr_o <= fetch_addr;
          instr_valid_o <= 1'b0;
        end else if (do_halt) begin
          // The fetched word is refetched after wake
          pc <= fetch_addr;
          instr_valid_o <= 1'b0;
          state <= ST_HALT;
        end else if (ext_take || timer_take) begin
          stk1 <= stk0;
          stk0 <= fetch_addr;
          stack_level <= stack_level + `PS_STK_ONE;
          pc <= ext_take ? `PS_VEC_EXT : `PS_VEC_TIMER;
          ext_int_ack_o <= ext_take;
          timer_int_ack_o <= timer_take;
          gie_clear_o <= 1'b1;
          instr_valid_o <= 1'b0;
        end else begin
          instr_o <= mem_q;
          exec_addr_o <= fetch_addr;
          instr_valid_o <= 1'b1;
        end
      end
      case (state)
        ST_RUN: begin
        end
        ST_HALT: begin
          if (wake_i) begin
            state <= ST_RUN;
          end
        end
        default: begin
          state <= ST_RUN;
        end
      endcase
    end
  end

  // stack entries not on bus
  // The stack has no bus path; only its fill level shows in status

endmodule // ps_sequencer

/* File: tb/ps_seq_checker.sv */
`timescale 1ns/1ns
// ****
// Port checks
// ****
module ps_seq_checker (
  input wire sys_clk_i,
  input wire reset_i,
  input wire avs_write_i,
  input wire ctl_jump_i,
  input wire ctl_call_i,
  input wire ctl_return_i,
  input wire ctl_return_int_i,
  input wire ctl_skip_i,
  input wire ctl_tab_last_i,
  input wire ctl_halt_i,
  input wire [10:0] ctl_target_i,
  input wire [7:0] ctl_dest_addr_i,
  input wire external_interrupt_flag_i,
  input wire ext_int_en_i,
  input wire instr_valid_o,
  input wire [10:0] exec_addr_o,
  input wire [3:0] phase_o,
  input wire cycle_end_o,
  input wire tab_low_we_o,
  input wire [7:0] tab_low_addr_o,
  input wire ext_int_ack_o,
  input wire timer_int_ack_o,
  input wire gie_clear_o
);
  // Saturates so a long run never wraps into a false start-up
  reg [10:0] up_cnt;
  // A pending bus write to the low pc byte outranks any decoder op
  wire run_op = cycle_end_o && instr_valid_o && !avs_write_i;
  wire hi_op = ctl_return_i || ctl_return_int_i || ctl_call_i;
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);
  always @(posedge sys_clk_i) begin
    if (reset_i) begin
      up_cnt <= 11'h000;
    end else if (up_cnt != 11'h7ff) begin
      up_cnt <= up_cnt + 11'h001;
    end
  end
  a_phase_walk: assert property (phase_o == 4'h2 |=> phase_o == 4'h4 ##1 phase_o == 4'h8)
    else $error("phase order");
  a_end_phase: assert property (cycle_end_o |-> phase_o == 4'h8)
    else $error("cycle end off phase");
  a_startup_wait: assert property (cycle_end_o |-> up_cnt > 11'h3ff)
    else $error("start-up too short");
  a_seq_step: assert property (run_op && !ctl_halt_i |=>
    !instr_valid_o || exec_addr_o == $past(exec_addr_o) + 11'h001) else $error("no increment");
  a_jump_land: assert property (run_op && ctl_jump_i && !hi_op |=>
    !instr_valid_o ##4 (!instr_valid_o || exec_addr_o == $past(ctl_target_i, 5))) else $error("jump");
  a_skip_two: assert property (run_op && ctl_skip_i && !hi_op && !ctl_jump_i |=>
    !instr_valid_o ##4 (!instr_valid_o || exec_addr_o == $past(exec_addr_o, 5) + 11'h002)) else $error("skip");
  a_table_two: assert property (run_op && ctl_tab_last_i && !hi_op && !ctl_jump_i && !ctl_skip_i |=>
    !instr_valid_o ##4 (tab_low_we_o && instr_valid_o && tab_low_addr_o == $past(ctl_dest_addr_i, 5)))
    else $error("table read");
  a_ext_vector: assert property (ext_int_ack_o |-> gie_clear_o ##4 (instr_valid_o && exec_addr_o == 11'h004))
    else $error("ext vector");
  a_timer_vector: assert property (timer_int_ack_o |-> gie_clear_o ##4 (instr_valid_o && exec_addr_o == 11'h008))
    else $error("timer vector");
  a_ext_first: assert property (timer_int_ack_o |->
    !ext_int_ack_o && !($past(external_interrupt_flag_i) && $past(ext_int_en_i))) else $error("priority");
endmodule // ps_seq_checker

bind ps_sequencer ps_seq_checker chk (.*);

/* File: tb/ps_partner.sv */
`timescale 1ns/1ns
// ****
// Decoder and interrupt logic model
// ****
module ps_partner (
  input wire sys_clk_i,
  input wire reset_i,
  input wire [13:0] instr_i,
  input wire instr_valid_i,
  input wire ext_ack_i,
  input wire timer_ack_i,
  input wire gie_clear_i,
  input wire gie_set_i,
  input wire ext_req_i,
  input wire timer_req_i,
  input wire gie_on_i,
  output wire [7:0] ctl_o,
  output reg ext_flag_o,
  output reg timer_flag_o,
  output reg gie_o
);
  // Opcode in the top three bits; bit 0 unused so code 0 is a plain op
  assign ctl_o = instr_valid_i ? ((8'h01 << instr_i[13:11]) & 8'hfe) : 8'h00;
  always @(posedge sys_clk_i) begin
    if (reset_i) begin
      ext_flag_o <= 1'b0;
      timer_flag_o <= 1'b0;
      gie_o <= 1'b0;
    end else begin
      ext_flag_o <= ext_req_i || (ext_flag_o && !ext_ack_i);
      timer_flag_o <= timer_req_i || (timer_flag_o && !timer_ack_i);
      gie_o <= gie_on_i || gie_set_i || (gie_o && !gie_clear_i);
    end
  end
endmodule // ps_partner

/* File: tb/testbench.sv */
`timescale 1ns/1ns
// ****
// Sequencer testbench
// ****
module testbench;
  reg sys_clk_i = 1'b0;
  reg reset_i = 1'b1;
  reg [7:0] avs_address_i = 8'h00;
  reg avs_read_i = 1'b0;
  reg avs_write_i = 1'b0;
  reg [31:0] avs_writedata_i = 32'h0000_0000;
  reg pm_wr_en_i = 1'b0;
  reg [10:0] pm_wr_addr_i = 11'h000;
  reg [13:0] pm_wr_data_i = 14'h0000;
  reg ext_int_en_i = 1'b0;
  reg timer_int_en_i = 1'b0;
  reg ext_req = 1'b0;
  reg timer_req = 1'b0;
  reg gie_on = 1'b0;
  reg [15:0] tab_got = 16'h0000;
  reg [31:0] rd_data;
  integer failures = 0;
  integer check_count = 0;
  wire [31:0] avs_readdata_o;
  wire [13:0] instr_o;
  wire [10:0] exec_addr_o;
  wire [3:0] phase_o;
  wire [7:0] tab_low_addr_o, tab_low_data_o, ctl;
  wire avs_waitrequest_o, instr_valid_o, cycle_end_o, tab_low_we_o, ext_int_ack_o, timer_int_ack_o;
  wire gie_clear_o, gie_set_o, ext_flag, timer_flag, gie;
  // Valid slots carry 0800 plus the address, dummy slots read 0fff
  logic [15:0] flow_exp [14] = '{16'h0800, 16'h0801, 16'h0fff, 16'h0810, 16'h0fff, 16'h0820, 16'h0fff,
    16'h0811, 16'h0fff, 16'h0812, 16'h0fff, 16'h0814, 16'h0fff, 16'h0914};
  ps_sequencer DUT (
    .avs_byteenable_i(4'h1),
    .ctl_jump_i(ctl[1]),
    .ctl_call_i(ctl[2]),
    .ctl_return_i(ctl[3]),
    .ctl_skip_i(ctl[4]),
    .ctl_tab_cur_i(ctl[5]),
    .ctl_tab_last_i(ctl[6]),
    .ctl_return_int_i(ctl[7]),
    .ctl_halt_i(1'b0),
    .ctl_target_i(instr_o[10:0]),
    .ctl_dest_addr_i(instr_o[7:0]),
    .wake_i(1'b0),
    .global_interrupt_enable_i(gie),
    .external_interrupt_flag_i(ext_flag),
    .timer_interrupt_flag_i(timer_flag),
    .*
  );
  ps_partner partner (
    .sys_clk_i(sys_clk_i),
    .reset_i(reset_i),
    .instr_i(instr_o),
    .instr_valid_i(instr_valid_o),
    .ext_ack_i(ext_int_ack_o),
    .timer_ack_i(timer_int_ack_o),
    .gie_clear_i(gie_clear_o),
    .gie_set_i(gie_set_o),
    .ext_req_i(ext_req),
    .timer_req_i(timer_req),
    .gie_on_i(gie_on),
    .ctl_o(ctl),
    .ext_flag_o(ext_flag),
    .timer_flag_o(timer_flag),
    .gie_o(gie)
  );
  always #4 sys_clk_i = ~sys_clk_i;
  always @(posedge sys_clk_i) begin
    if (tab_low_we_o === 1'b1) begin
      tab_got <= {tab_low_addr_o, tab_low_data_o};
    end
  end
  task check(input string name, input [15:0] want, input [15:0] seen);
    begin
      check_count = check_count + 1;
      if (seen !== want) begin
        failures = failures + 1;
        $display("unexpected %s: expected %h seen %h", name, want, seen);
      end
    end
  endtask
  // Request held until waitrequest is sampled low, then released
  task bus(input wr, input [7:0] addr, input [7:0] data);
    integer n;
    begin
      n = 0;
      avs_address_i <= addr;
      avs_writedata_i <= {24'h00_0000, data};
      avs_read_i <= !wr;
      avs_write_i <= wr;
      @(posedge sys_clk_i);
      while (avs_waitrequest_o !== 1'b0 && n < 50) begin
        @(posedge sys_clk_i);
        n = n + 1;
      end
      if (n >= 50) failures = failures + 1;
      rd_data = avs_readdata_o;
      avs_read_i <= 1'b0;
      avs_write_i <= 1'b0;
      @(posedge sys_clk_i);
    end
  endtask
  task pm(input [10:0] addr, input [13:0] word);
    begin
      pm_wr_en_i <= 1'b1;
      pm_wr_addr_i <= addr;
      pm_wr_data_i <= word;
      @(posedge sys_clk_i);
    end
  endtask
  // Returns what the next instruction cycle executes
  task cycle(output [15:0] seen);
    integer n;
    begin
      n = 0;
      @(posedge sys_clk_i);
      while (cycle_end_o !== 1'b1 && n < 2000) begin
        @(posedge sys_clk_i);
        n = n + 1;
      end
      if (n >= 2000) failures = failures + 1;
      @(posedge sys_clk_i);
      seen = (instr_valid_o === 1'b1) ? {5'h01, exec_addr_o} : 16'h0fff;
    end
  endtask
  task load_prog;
    begin
      pm(11'h000, 14'h0000);
      pm(11'h001, 14'h0810);
      pm(11'h010, 14'h1020);
      pm(11'h011, 14'h3040);
      pm(11'h012, 14'h2000);
      pm(11'h014, 14'h0914);
      pm(11'h020, 14'h1800);
      pm(11'h114, 14'h0914);
      pm(11'h140, 14'h0940);
      pm(11'h004, 14'h3800);
      pm(11'h008, 14'h3800);
      pm(11'h7aa, 14'h2a5c);
      pm_wr_en_i <= 1'b0;
      @(posedge sys_clk_i);
    end
  endtask
  task test_regs;
    begin
      bus(1'b0, 8'h18, 8'h00);
      check("pc_low_byte", 16'h0000, rd_data[15:0]);
      bus(1'b0, 8'h1c, 8'h00);
      check("table_pointer", 16'h0000, rd_data[15:0]);
      bus(1'b0, 8'h3c, 8'h00);
      check("unmapped", 16'h0000, rd_data[15:0]);
      bus(1'b1, 8'h20, 8'h55);
      bus(1'b0, 8'h20, 8'h00);
      check("table_high_byte", 16'h0000, rd_data[15:0]);
      bus(1'b1, 8'h1c, 8'haa);
      bus(1'b0, 8'h1c, 8'h00);
      check("table_pointer", 16'h00aa, rd_data[15:0]);
    end
  endtask
  task test_flow;
    integer i;
    reg [15:0] seen;
    begin
      for (i = 0; i < 14; i = i + 1) begin
        cycle(seen);
        check("exec_addr", flow_exp[i], seen);
      end
      check("table_low", 16'h405c, tab_got);
      bus(1'b0, 8'h20, 8'h00);
      check("table_high_byte", 16'h002a, rd_data[15:0]);
    end
  endtask
  task test_pcl;
    integer i;
    reg [15:0] seen;
    begin
      bus(1'b1, 8'h18, 8'h40);
      seen = 16'h0914;
      for (i = 0; i < 8 && (seen === 16'h0914 || seen === 16'h0fff); i = i + 1) begin
        cycle(seen);
      end
      check("pc_low_jump", 16'h0940, seen);
    end
  endtask
  task test_irq;
    integer i;
    integer k;
    reg [15:0] seen;
    begin
      ext_int_en_i <= 1'b1;
      timer_int_en_i <= 1'b1;
      ext_req <= 1'b1;
      timer_req <= 1'b1;
      gie_on <= 1'b1;
      @(posedge sys_clk_i);
      ext_req <= 1'b0;
      timer_req <= 1'b0;
      gie_on <= 1'b0;
      k = 0;
      for (i = 0; i < 40 && k < 2; i = i + 1) begin
        cycle(seen);
        if (seen !== 16'h0940 && seen !== 16'h0fff) begin
          check("vector", (k == 0) ? 16'h0804 : 16'h0808, seen);
          k = k + 1;
        end
      end
      cycle(seen);
      cycle(seen);
      check("resume", 16'h0940, seen);
      check("flags", 16'h0000, {14'h0000, ext_flag, timer_flag});
      bus(1'b0, 8'h30, 8'h00);
      check("status", 16'h0000, rd_data[15:0] & 16'he800);
    end
  endtask
  task stop_test;
    begin
      if (failures == 0 && check_count > 0) begin
        $display("Test passed");
      end else begin
        $display("Test failed");
      end
      $finish;
    end
  endtask
  // Start-up alone is over a thousand clocks; allow about four times the run
  initial begin
    #40000;
    failures = failures + 1;
    stop_test;
  end
  initial begin
    repeat (16) @(posedge sys_clk_i);
    reset_i <= 1'b0;
    load_prog;
    test_regs;
    test_flow;
    test_pcl;
    test_irq;
    stop_test;
  end
endmodule // testbench
